// *** verilog/acs_pkg.sv ***
package acs_pkg;

  // register offsets
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_IER  = 3'h1;
  localparam logic [2:0] A_IIR  = 3'h2;
  localparam logic [2:0] A_LCR  = 3'h3;
  localparam logic [2:0] A_MCR  = 3'h4;
  localparam logic [2:0] A_LSR  = 3'h5;
  localparam logic [2:0] A_MSR  = 3'h6;
  localparam logic [2:0] A_SCR  = 3'h7;

  // field positions
  localparam int LCR_STB   = 2;
  localparam int LCR_PEN   = 3;
  localparam int LCR_EPS   = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK   = 6;
  localparam int LCR_DIVISOR_ACCESS_BIT  = 7;
  localparam int MCR_LOOP  = 4;

  // values after reset
  localparam logic [15:0] RST_DIV = 16'h000C;
  localparam logic [7:0]  RST_LCR = 8'h03;
  localparam logic [4:0]  RST_MCR = 5'h00;
  localparam logic [3:0]  RST_IER = 4'h0;

  // cycle counts, in 16x ticks, and the word length base
  localparam logic [5:0] TK_BIT  = 6'h10;
  localparam logic [5:0] TK_ST15 = 6'h18;
  localparam logic [5:0] TK_ST2  = 6'h20;
  localparam logic [3:0] RX_MID  = 4'h7;
  localparam logic [3:0] RX_LAST = 4'hF;
  localparam logic [3:0] WL_BASE = 4'h5;

  // interrupt source codes
  localparam logic [1:0] ID_LS  = 2'h3;
  localparam logic [1:0] ID_RDA = 2'h2;
  localparam logic [1:0] ID_THR = 2'h1;
  localparam logic [1:0] ID_MS  = 2'h0;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} acs_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_MARK} acs_rx_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_req_s;

  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } acs_modem_s;

  typedef struct packed {
    logic dtr;
    logic rts;
    logic out1;
    logic out2;
  } acs_mctl_s;

  // parity bit for the data bits selected by the word length
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] line_control);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - line_control[1:0]);
    par_of = line_control[LCR_STICK] ? ~line_control[LCR_EPS] : (line_control[LCR_EPS] ? ^(d & m) : ~^(d & m));
  endfunction

endpackage

// *** verilog/acs_uart.sv ***
// Our own choice: the strobed register port.
`timescale 1ns/100ps

module acs_uart
  import acs_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire acs_req_s   bus_req,
  output logic [7:0]      reg_rdata,
  // serial pins
  input  wire logic       sin,
  output logic            sout,
  // modem pins, active low
  input  wire acs_modem_s modem_in_n,
  output acs_mctl_s       modem_out_n,
  // interrupt request
  output logic            irq
);

  logic [15:0] div_r;
  logic [7:0]  lcr_r;
  logic [4:0]  mcr_r;
  logic [3:0]  ier_r;
  logic [7:0]  scr_r;
  logic [7:0]  thr_r;
  logic [7:0]  rbr_r;
  logic        tx_holding_empty_r;
  logic        dr_r;
  logic [3:0]  err_r;
  logic [3:0]  delta_r;
  logic [7:0]  rdata_r;
  logic        irq_r;
  logic        sout_r;
  acs_mctl_s   mout_r;

  logic [15:0] bcnt_r;
  logic        tick;
  logic        divisor_access_bit;
  logic        loop;
  logic [3:0]  nbits;

  logic        sin_s1_r;
  logic        sin_s2_r;
  acs_modem_s  mdm_s1_r;
  acs_modem_s  mdm_s2_r;
  acs_modem_s  ms_now;
  acs_modem_s  ms_prev_r;

  acs_tx_e     tx_st_r;
  logic [5:0]  tsub_r;
  logic [3:0]  tbit_r;
  logic [7:0]  tsh_r;
  logic        tpar_r;
  logic        tx_line_r;
  logic        lb_line;
  logic [5:0]  stop_len;

  acs_rx_e     rx_st_r;
  logic [3:0]  rsub_r;
  logic [3:0]  rbit_r;
  logic [7:0]  rsh_r;
  logic        rpar_r;
  logic        rx_in;
  logic        rx_done;
  logic [7:0]  rdat;
  logic [3:0]  err_set;
  logic [3:0]  chg;

  logic        rd_rbr;
  logic        rd_lsr;
  logic        rd_msr;
  logic        wr_thr;
  logic [7:0]  lsr_w;
  logic [7:0]  msr_w;
  logic [7:0]  iir_w;
  logic [7:0]  rd_mux;
  logic        pend;
  logic [1:0]  iid;
  logic        temt;

  assign divisor_access_bit  = lcr_r[LCR_DIVISOR_ACCESS_BIT];
  assign loop  = mcr_r[MCR_LOOP];
  assign nbits = WL_BASE + {2'h0, lcr_r[1:0]};

  assign rd_rbr = bus_req.rd && bus_req.addr == A_DATA && !divisor_access_bit;
  assign rd_lsr = bus_req.rd && bus_req.addr == A_LSR;
  assign rd_msr = bus_req.rd && bus_req.addr == A_MSR;
  assign wr_thr = bus_req.wr && bus_req.addr == A_DATA && !divisor_access_bit;

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sin_s1_r <= 1'b1;
      sin_s2_r <= 1'b1;
      mdm_s1_r <= 4'hF;
      mdm_s2_r <= 4'hF;
    end else begin
      sin_s1_r <= sin;
      sin_s2_r <= sin_s1_r;
      mdm_s1_r <= modem_in_n;
      mdm_s2_r <= mdm_s1_r;
    end
  end

  // register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_r <= RST_DIV;
      lcr_r <= RST_LCR;
      mcr_r <= RST_MCR;
      ier_r <= RST_IER;
      scr_r <= 8'h00;
      thr_r <= 8'h00;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        A_DATA: begin
          if (divisor_access_bit)
            div_r[7:0] <= bus_req.wdata;
          else
            thr_r <= bus_req.wdata;
        end
        A_IER: begin
          if (divisor_access_bit)
            div_r[15:8] <= bus_req.wdata;
          else
            ier_r <= bus_req.wdata[3:0];
        end
        A_LCR: lcr_r <= bus_req.wdata;
        A_MCR: mcr_r <= bus_req.wdata[4:0];
        A_SCR: scr_r <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // 16x tick from the divisor
  assign tick = bcnt_r >= div_r - 16'h0001;

  always_ff @(posedge core_clk) begin
    if (rst)
      bcnt_r <= 16'h0000;
    else if (tick)
      bcnt_r <= 16'h0000;
    else
      bcnt_r <= bcnt_r + 16'h0001;
  end

  // transmitter
  assign stop_len = !lcr_r[LCR_STB] ? TK_BIT :
                    (lcr_r[1:0] == 2'h0 ? TK_ST15 : TK_ST2);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_st_r   <= TX_IDLE;
      tsub_r    <= 6'h00;
      tbit_r    <= 4'h0;
      tsh_r     <= 8'h00;
      tpar_r    <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          if (!tx_holding_empty_r) begin
            tsh_r     <= thr_r;
            tpar_r    <= par_of(thr_r, lcr_r);
            tx_st_r   <= TX_START;
            tsub_r    <= 6'h00;
            tx_line_r <= 1'b0;
          end
        end
        TX_START, TX_DATA, TX_PAR: begin
          if (tick) begin
            tsub_r <= tsub_r + 6'h01;
            if (tsub_r == TK_BIT - 6'h01) begin
              tsub_r <= 6'h00;
              if (tx_st_r == TX_START) begin
                tx_st_r   <= TX_DATA;
                tbit_r    <= 4'h0;
                tx_line_r <= tsh_r[0];
              end else if (tx_st_r == TX_DATA && tbit_r != nbits - 4'h1) begin
                tbit_r    <= tbit_r + 4'h1;
                tsh_r     <= {1'b0, tsh_r[7:1]};
                tx_line_r <= tsh_r[1];
              end else if (tx_st_r == TX_DATA && lcr_r[LCR_PEN]) begin
                tx_st_r   <= TX_PAR;
                tx_line_r <= tpar_r;
              end else begin
                tx_st_r   <= TX_STOP;
                tx_line_r <= 1'b1;
              end
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            tsub_r <= tsub_r + 6'h01;
            if (tsub_r == stop_len - 6'h01) begin
              tsub_r  <= 6'h00;
              tx_st_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // holding register empty flag
  always_ff @(posedge core_clk) begin
    if (rst)
      tx_holding_empty_r <= 1'b1;
    else if (wr_thr)
      tx_holding_empty_r <= 1'b0;
    else if (tx_st_r == TX_IDLE)
      tx_holding_empty_r <= 1'b1;
  end

  assign temt    = tx_holding_empty_r && tx_st_r == TX_IDLE;
  assign lb_line = lcr_r[LCR_BRK] ? 1'b0 : tx_line_r;

  // serial and modem outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sout_r <= 1'b1;
      mout_r <= 4'hF;
    end else begin
      sout_r <= loop ? 1'b1 : lb_line;
      mout_r <= loop ? 4'hF : ~{mcr_r[0], mcr_r[1], mcr_r[2], mcr_r[3]};
    end
  end

  // receiver
  assign rx_in   = loop ? lb_line : sin_s2_r;
  assign rx_done = rx_st_r == RX_STOP && tick && rsub_r == RX_LAST;
  assign rdat    = rsh_r >> (4'h8 - nbits);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_st_r <= RX_IDLE;
      rsub_r  <= 4'h0;
      rbit_r  <= 4'h0;
      rsh_r   <= 8'h00;
      rpar_r  <= 1'b0;
    end else begin
      unique case (rx_st_r)
        RX_IDLE: begin
          rsub_r <= 4'h0;
          if (!rx_in)
            rx_st_r <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == RX_MID) begin
              rsub_r  <= 4'h0;
              rbit_r  <= 4'h0;
              rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == RX_LAST) begin
              rsh_r  <= {rx_in, rsh_r[7:1]};
              rbit_r <= rbit_r + 4'h1;
              if (rbit_r == nbits - 4'h1)
                rx_st_r <= lcr_r[LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == RX_LAST) begin
              rpar_r  <= rx_in;
              rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rsub_r <= rsub_r + 4'h1;
            if (rsub_r == RX_LAST)
              rx_st_r <= rx_in ? RX_IDLE : RX_MARK;
          end
        end
        RX_MARK: begin
          if (rx_in)
            rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // line status: {break, framing, parity, overrun}
  assign err_set[0] = rx_done && dr_r;
  assign err_set[1] = rx_done && lcr_r[LCR_PEN] && rpar_r != par_of(rdat, lcr_r);
  assign err_set[2] = rx_done && !rx_in;
  assign err_set[3] = rx_done && !rx_in && rdat == 8'h00 && !(lcr_r[LCR_PEN] && rpar_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rbr_r <= 8'h00;
      dr_r  <= 1'b0;
      err_r <= 4'h0;
    end else begin
      if (rx_done)
        rbr_r <= rdat;
      dr_r  <= rx_done || (dr_r && !rd_rbr);
      err_r <= err_set | (rd_lsr ? 4'h0 : err_r);
    end
  end

  assign lsr_w = {1'b0, temt, tx_holding_empty_r, err_r, dr_r};

  // modem status
  assign ms_now = loop ? {mcr_r[1], mcr_r[0], mcr_r[2], mcr_r[3]} : ~mdm_s2_r;

  assign chg = {ms_prev_r.dcd ^ ms_now.dcd,
                ms_prev_r.ri && !ms_now.ri,
                ms_prev_r.dsr ^ ms_now.dsr,
                ms_prev_r.cts ^ ms_now.cts};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ms_prev_r <= 4'h0;
      delta_r   <= 4'h0;
    end else begin
      ms_prev_r <= ms_now;
      delta_r   <= chg | (rd_msr ? 4'h0 : delta_r);
    end
  end

  assign msr_w = {ms_now.dcd, ms_now.ri, ms_now.dsr, ms_now.cts, delta_r};

  // interrupt identification
  always_comb begin
    pend = 1'b1;
    iid  = ID_MS;
    if (ier_r[2] && err_r != 4'h0)
      iid = ID_LS;
    else if (ier_r[0] && dr_r)
      iid = ID_RDA;
    else if (ier_r[1] && tx_holding_empty_r)
      iid = ID_THR;
    else if (ier_r[3] && delta_r != 4'h0)
      iid = ID_MS;
    else
      pend = 1'b0;
  end

  assign iir_w = {5'h00, iid, ~pend};

  // read data, valid for one cycle
  always_comb begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      A_DATA: rd_mux = divisor_access_bit ? div_r[7:0] : rbr_r;
      A_IER:  rd_mux = divisor_access_bit ? div_r[15:8] : {4'h0, ier_r};
      A_IIR:  rd_mux = iir_w;
      A_LCR:  rd_mux = lcr_r;
      A_MCR:  rd_mux = {3'h0, mcr_r};
      A_LSR:  rd_mux = lsr_w;
      A_MSR:  rd_mux = msr_w;
      A_SCR:  rd_mux = scr_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
      irq_r   <= pend;
    end
  end

  assign reg_rdata   = rdata_r;
  assign sout        = sout_r;
  assign modem_out_n = mout_r;
  assign irq         = irq_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  lsr_read_a: assert property (
    rd_lsr |=> reg_rdata == $past(lsr_w))
    else $error("line status read data wrong");

  div_low_a: assert property (
    bus_req.wr && bus_req.addr == A_DATA && divisor_access_bit |=> div_r[7:0] == $past(bus_req.wdata))
    else $error("divisor low byte not written");

  thr_load_a: assert property (
    wr_thr |=> !tx_holding_empty_r ##0 !temt)
    else $error("holding write did not clear empty");

  break_out_a: assert property (
    lcr_r[LCR_BRK] && !loop ##1 lcr_r[LCR_BRK] && !loop |-> !sout)
    else $error("break not driven on serial out");

  loop_mark_a: assert property (
    loop |=> sout && modem_out_n == 4'hF)
    else $error("loopback outputs not idle");

  dr_clear_a: assert property (
    rd_rbr && !rx_done |=> !dr_r)
    else $error("ready not cleared by data read");

  iir_pend_a: assert property (
    ier_r[0] && dr_r |-> !iir_w[0] && iir_w[2:1] != ID_MS)
    else $error("pending interrupt not reported");

  cts_delta_a: assert property (
    $changed(ms_now.cts) |=> delta_r[0])
    else $error("cts change not flagged");

  tick_gap_a: assert property (
    tick && div_r > 16'h0002 && $stable(div_r) |=> (!tick || div_r < 16'h0003) [*2])
    else $error("tick repeats too soon");

  rx_start_a: assert property (
    rx_st_r == RX_IDLE && !rx_in |=> rx_st_r == RX_START)
    else $error("receiver missed start edge");

endmodule

// *** testbench/acs_term.sv ***
`timescale 1ns/100ps

// serial terminal on the far side of the line
module acs_term
  import acs_pkg::*;
(
  // clock
  input  wire logic core_clk,
  // serial pins
  input  wire logic sout,
  output logic      sin,
  // modem pins, active low
  output acs_modem_s modem_in_n
);
  localparam int BIT_CYC = 16;
  int cyc;

  initial begin
    sin = 1'b1;
    modem_in_n = 4'hF;
    cyc = 0;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
  end

  // frame out: start, data lsb first, optional parity, stop
  task automatic send(input logic [7:0] d, input int nb, input logic parity_enable,
                      input logic pb, input logic stp);
    @(posedge core_clk) sin <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk);
    for (int k = 0; k < nb; k++) begin
      sin <= d[k];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    if (parity_enable) begin
      sin <= pb;
      repeat (BIT_CYC) @(posedge core_clk);
    end
    sin <= stp;
    repeat (BIT_CYC) @(posedge core_clk);
    sin <= 1'b1;
  endtask

  // frame in: each bit sampled in its middle
  task automatic recv(input int nb, input logic parity_enable, output logic [7:0] d,
                      output logic pb, output logic stp, output int t0);
    d = 8'h00;
    pb = 1'b0;
    @(negedge sout);
    t0 = cyc;
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int k = 0; k < nb; k++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      d[k] = sout;
    end
    if (parity_enable) begin
      repeat (BIT_CYC) @(posedge core_clk);
      pb = sout;
    end
    repeat (BIT_CYC) @(posedge core_clk);
    stp = sout;
  endtask

  // modem lines change just after an edge
  task automatic set_modem(input logic [3:0] v);
    @(posedge core_clk) modem_in_n <= v;
  endtask
endmodule

// *** testbench/test_async_serial_comm_element.sv ***
`timescale 1ns/100ps

module test_async_serial_comm_element
  import acs_pkg::*;
;
  logic        core_clk;
  logic        rst;
  acs_req_s    bus_req;
  logic [7:0]  reg_rdata;
  logic        sin;
  logic        sout;
  logic        irq;
  acs_modem_s  modem_in_n;
  acs_mctl_s   modem_out_n;
  int          err_total;
  int          checks;
  logic [31:0] seed;
  logic [7:0]  d;
  logic [7:0]  e;
  logic [7:0]  line_control;
  logic [7:0]  x;
  logic        pb;
  logic        stp;
  int          t0;
  int          t1;
  int          nb;
  int          len;

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  acs_uart i_acs_uart (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .sin(sin), .sout(sout), .modem_in_n(modem_in_n),
    .modem_out_n(modem_out_n), .irq(irq));
  acs_term i_acs_term (.core_clk(core_clk), .sout(sout), .sin(sin),
    .modem_in_n(modem_in_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] l);
    wmask = 8'hFF >> (2'h3 - l[1:0]);
  endfunction

  function automatic logic exp_par(input logic [7:0] v, input logic [7:0] l);
    if (l[5]) exp_par = ~l[4];
    else exp_par = l[4] ? ^(v & wmask(l)) : ~^(v & wmask(l));
  endfunction

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= v;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] v;
    rd_reg(a, v);
    chk(nm, ex, v);
  endtask

  task automatic print_verdict;
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    print_verdict;
  end

  initial begin
    rst = 1'b1;
    bus_req = '0;
    err_total = 0;
    checks = 0;
    seed = 32'hB837;
    wait_cyc(20);
    rst <= 1'b0;
    // reset values and read-only places
    rd_chk(A_LCR, 8'h03, "lcr");
    rd_chk(A_LSR, 8'h60, "lsr");
    rd_chk(A_IIR, 8'h01, "iir");
    wr_reg(A_IIR, 8'hFF);
    rd_chk(A_IIR, 8'h01, "iir_ro");
    wr_reg(A_IER, 8'hFF);
    rd_chk(A_IER, 8'h0F, "ier");
    rd_chk(A_IIR, 8'h02, "iir_thr");
    chk("irq", 8'h01, {7'h00, irq});
    wr_reg(A_IER, 8'h00);
    seed = xs(seed);
    wr_reg(A_SCR, seed[7:0]);
    rd_chk(A_SCR, seed[7:0], "scratch");
    // divisor bytes behind the access bit
    wr_reg(A_LCR, 8'h83);
    wr_reg(A_DATA, seed[15:8]);
    wr_reg(A_IER, seed[23:16]);
    rd_chk(A_DATA, seed[15:8], "div_lo");
    rd_chk(A_IER, seed[23:16], "div_hi");
    rd_chk(A_LCR, 8'h83, "lcr_divisor_access_bit");
    wr_reg(A_DATA, 8'h01);
    wr_reg(A_IER, 8'h00);
    wr_reg(A_LCR, 8'h03);
    rd_chk(A_IER, 8'h00, "ier_back");
    // break on the line
    wr_reg(A_LCR, 8'h43);
    wait_cyc(2);
    chk("brk", 8'h00, {7'h00, sout});
    wr_reg(A_LCR, 8'h03);
    wait_cyc(40);
    // transmit, two frames back to back
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      line_control = {2'b00, seed[5:0]};
      line_control[1:0] = 2'(i);
      line_control[2] = i[2];
      nb = 5 + int'(line_control[1:0]);
      wr_reg(A_LCR, line_control);
      fork
        begin
          wr_reg(A_DATA, seed[15:8]);
          wait_cyc(4);
          wr_reg(A_DATA, seed[23:16]);
        end
        begin
          i_acs_term.recv(nb, line_control[3], d, pb, stp, t0);
          chk("tx_data", seed[15:8] & wmask(line_control), d);
          chk("tx_par", {7'h00, exp_par(seed[15:8], line_control) & line_control[3]}, {7'h00, pb});
          chk("tx_stop", 8'h01, {7'h00, stp});
          i_acs_term.recv(nb, line_control[3], d, pb, stp, t1);
          chk("tx_data2", seed[23:16] & wmask(line_control), d);
        end
      join
      len = 16 * (1 + nb + int'(line_control[3])) + (!line_control[2] ? 16 : (line_control[1:0] == 2'h0 ? 24 : 32));
      chk("tx_len", 8'h01, {7'h00, t1 - t0 == len + 1});
      wait_cyc(40);
    end
    // receive, last frame with a wrong parity bit
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      line_control = {2'b00, seed[5:0]};
      line_control[2] = 1'b0;
      if (i == 5) line_control[3] = 1'b1;
      wr_reg(A_LCR, line_control);
      pb = exp_par(seed[15:8], line_control) ^ (i == 5);
      i_acs_term.send(seed[15:8], 5 + int'(line_control[1:0]), line_control[3], pb, 1'b1);
      wait_cyc(4);
      e = (i == 5) ? 8'h65 : 8'h61;
      rd_chk(A_LSR, e, "lsr_rx");
      rd_chk(A_DATA, seed[15:8] & wmask(line_control), "rbr");
      rd_chk(A_LSR, 8'h60, "lsr_clr");
    end
    // overrun and interrupt priority
    wr_reg(A_LCR, 8'h03);
    wr_reg(A_IER, 8'h0F);
    i_acs_term.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    i_acs_term.send(8'h3C, 8, 1'b0, 1'b0, 1'b1);
    wait_cyc(4);
    rd_chk(A_IIR, 8'h06, "iir_ls");
    rd_chk(A_LSR, 8'h63, "lsr_ovr");
    rd_chk(A_IIR, 8'h04, "iir_rda");
    rd_chk(A_DATA, 8'h3C, "rbr_ovr");
    rd_chk(A_IIR, 8'h02, "iir_thr2");
    i_acs_term.send(8'h00, 8, 1'b0, 1'b0, 1'b0);
    wait_cyc(4);
    rd_reg(A_LSR, d);
    chk("lsr_brk", 8'h10, d & 8'h10);
    rd_reg(A_DATA, d);
    wait_cyc(20);
    // modem status changes
    wr_reg(A_IER, 8'h08);
    rd_reg(A_MSR, d);
    i_acs_term.set_modem(4'b0110);
    wait_cyc(6);
    rd_chk(A_IIR, 8'h00, "iir_ms");
    rd_chk(A_MSR, 8'h99, "msr_chg");
    rd_chk(A_MSR, 8'h90, "msr_clr");
    rd_chk(A_IIR, 8'h01, "iir_none");
    i_acs_term.set_modem(4'b0100);
    wait_cyc(6);
    rd_chk(A_MSR, 8'hD0, "msr_ri_on");
    i_acs_term.set_modem(4'b0110);
    wait_cyc(6);
    rd_chk(A_MSR, 8'h94, "msr_ri_off");
    wr_reg(A_IER, 8'h00);
    // modem control and loopback of the modem lines
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      x = {3'b000, i[0], seed[3:0]};
      wr_reg(A_MCR, x);
      wait_cyc(6);
      rd_chk(A_MCR, x, "mcr");
      if (x[4]) begin
        chk("mout_loop", 8'h0F, {4'h0, modem_out_n});
        rd_reg(A_MSR, d);
        chk("msr_loop", {x[3], x[2], x[0], x[1], 4'h0}, d & 8'hF0);
      end else begin
        chk("mout", {4'h0, ~{x[0], x[1], x[2], x[3]}}, {4'h0, modem_out_n});
      end
    end
    // serial loopback
    wr_reg(A_MCR, 8'h10);
    seed = xs(seed);
    wr_reg(A_DATA, seed[7:0]);
    wait_cyc(100);
    chk("sout_loop", 8'h01, {7'h00, sout});
    wait_cyc(150);
    rd_chk(A_DATA, seed[7:0], "rbr_loop");
    wr_reg(A_MCR, 8'h00);
    print_verdict;
  end
endmodule
